/* inc/ssq_pkg.sv */
package ssq_pkg;
	localparam int AXI_AW = 5;
	localparam logic [4:0] CTRL_OFF = 5'h00;
	localparam logic [4:0] CUR_OFF = 5'h04;
	localparam logic [4:0] STAT_OFF = 5'h08;
	localparam logic [4:0] INT_STAT_OFF = 5'h0c;
	localparam logic [4:0] INT_EN_OFF = 5'h10;
	localparam logic [4:0] INT_CLR_OFF = 5'h14;
	localparam int CTRL_DEDGE = 0;
	localparam int CTRL_INTPOL = 1;
	localparam int CTRL_EXT = 2;
	localparam int CTRL_MRES_LSB = 4;
	localparam int CUR_HOLD_LSB = 0;
	localparam int CUR_RUN_LSB = 8;
	localparam int ST_STST_BIT = 16;
	localparam int ST_SCALE_LSB = 24;
	localparam logic [31:0] CTRL_RST = 32'h0000_0004;
	localparam logic [31:0] CTRL_MASK = 32'h0000_00f7;
	localparam logic [31:0] CUR_RST = 32'h0000_1f08;
	localparam logic [31:0] CUR_MASK = 32'h0000_1f1f;
	localparam int INT_W = 3;
	localparam int INT_STST_ON = 0;
	localparam int INT_STST_OFF = 1;
	localparam int INT_INDEX = 2;
	localparam logic [3:0] MRES_MAX = 4'h8;
	localparam int MS_W = 10;
	localparam int HALF_LEN = 512;
	localparam logic [9:0] COS_OFF = 10'h100;
	localparam int SINE_PEAK = 255;
	localparam int unsigned STST_LIMIT = 1048576;
	localparam int ICNT_W = 21;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {
		SSQ_W_IDLE = 2'h1,
		SSQ_W_RESP = 2'h2
	} ssq_wstate_t;
	// rational sine fit, good to well under one lsb of an 8-bit amplitude
	function automatic int sine_mag(input int i);
		int p;
		p = i * (HALF_LEN - i);
		return (SINE_PEAK * 16 * p) / (5 * HALF_LEN * HALF_LEN - 4 * p);
	endfunction
endpackage

/* verilog/ssq_sync.sv */
`timescale 1ns/1ps
module ssq_sync #(
	parameter int W = 1
) (
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta <= '0;
			q    <= '0;
		end else begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule

/* verilog/ssq_wave.sv */
`timescale 1ns/1ps
module ssq_wave (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic        [9:0] idx,
	output logic signed      [8:0] amp
);
	// second half-wave is the first negated, so 512 stored magnitudes give all 1024 entries
	logic [7:0] half_tab [0:ssq_pkg::HALF_LEN-1];

	for (genvar i = 0; i < ssq_pkg::HALF_LEN; i++) begin : g_tab
		assign half_tab[i] = 8'(ssq_pkg::sine_mag(i));
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			amp <= 9'sh000;
		else if (idx[9])
			amp <= -$signed({1'b0, half_tab[idx[8:0]]});
		else
			amp <= $signed({1'b0, half_tab[idx[8:0]]});
	end
endmodule

/* verilog/ssq_sequencer.sv */
// Function
// R1 - dual-edge bit set: both step edges count; cleared: rising edges only
// R2 - step and direction pins are synchronised to the system clock before use
// R3 - a 1024-entry sine table covers one electrical turn, indexed by the counter
// R4 - each active edge adds the step width on direction 0, subtracts on 1
// R5 - step width is 1 at finest resolution doubling up to 256 at fullstep
// R6 - switching to coarser resolution snaps the counter to the nearest valid position
// R7 - fullstep cycles through 128, 384, 640, 896 in steps of 256
// R8 - half step starts at 64 step 128; quarter starts at 32 step 64
// R9 - internal motion control may be off any time; current settings stay active
// R10 - interpolation emits 2 to 256 fine microsteps per active edge; here 1 at finest resolution
// R11 - interpolation works only while its enable bit is set
// R12 - microstep spacing is previous interval split equally, limited near 2^20 cycles
// R13 - standstill flag sets when the interval passes the limit, clears on next edge
// R14 - in standstill the current scale switches from run to hold current
// R15 - step source keeps 50% duty before enabling dual-edge stepping
// R16 - new rate used after one full interval; unsent microsteps jump at next edge
// R17 - without interpolation, width applies the cycle after the synchronised edge
//
// Chosen here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
module ssq_sequencer #(
	parameter int unsigned STST_CYC = ssq_pkg::STST_LIMIT
) (
	input  wire logic                      aclk,
	input  wire logic                      aresetn,
	input  wire logic [ssq_pkg::AXI_AW-1:0] awaddr,
	input  wire logic                      awvalid,
	output logic                           awready,
	input  wire logic               [31:0] wdata,
	input  wire logic                [3:0] wstrb,
	input  wire logic                      wvalid,
	output logic                           wready,
	output logic                     [1:0] bresp,
	output logic                           bvalid,
	input  wire logic                      bready,
	input  wire logic [ssq_pkg::AXI_AW-1:0] araddr,
	input  wire logic                      arvalid,
	output logic                           arready,
	output logic                    [31:0] rdata,
	output logic                     [1:0] rresp,
	output logic                           rvalid,
	input  wire logic                      rready,
	input  wire logic                      step_in,
	input  wire logic                      dir_in,
	output logic signed              [8:0] coil_a,
	output logic signed              [8:0] coil_b,
	output logic                     [4:0] cur_scale,
	output logic                     [9:0] mscnt,
	output logic                           stst,
	output logic                           irq
);
	localparam logic [ssq_pkg::ICNT_W-1:0] LIM = ssq_pkg::ICNT_W'(STST_CYC);

	ssq_pkg::ssq_wstate_t       wst;
	logic                       aw_have;
	logic                       w_have;
	logic [ssq_pkg::AXI_AW-1:0] waddr;
	logic                [31:0] wdata_q;
	logic                 [3:0] wstrb_q;
	logic                [31:0] wmask;
	logic                       do_write;
	logic                       wr_ok;
	logic                [31:0] rd_word;
	logic                       rd_ok;
	logic                [31:0] ctrl;
	logic                [31:0] cur;
	logic   [ssq_pkg::INT_W-1:0] int_status;
	logic   [ssq_pkg::INT_W-1:0] int_en;
	logic   [ssq_pkg::INT_W-1:0] int_clr;
	logic   [ssq_pkg::INT_W-1:0] int_ev;
	logic                 [1:0] pin_s;
	logic                       step_s;
	logic                       dir_s;
	logic                       step_q;
	logic                       act;
	logic                       dedge;
	logic                       intpol;
	logic                       ext_mode;
	logic                 [3:0] mres;
	logic                 [3:0] n;
	logic                 [3:0] n_prev;
	logic                       res_lower;
	logic                 [9:0] wid;
	logic                 [9:0] base;
	logic                 [9:0] next_mscnt;
	logic [ssq_pkg::ICNT_W-1:0] icnt;
	logic [ssq_pkg::ICNT_W-1:0] spacing;
	logic [ssq_pkg::ICNT_W-1:0] next_spacing;
	logic [ssq_pkg::ICNT_W-1:0] tcnt;
	logic                       tick;
	logic                 [8:0] remaining;
	logic                       ip_dir;

	function automatic logic [9:0] snap(input logic [9:0] c, input logic [3:0] k);
		logic [9:0] m;
		m = 10'h3ff << k;
		snap = (k == 4'h0) ? c : ((c & m) | (10'h001 << (k - 4'h1)));
	endfunction

	// ---------------- register bus ----------------
	assign wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
	assign do_write = (wst == ssq_pkg::SSQ_W_IDLE) && aw_have && w_have;
	assign wr_ok = (waddr == ssq_pkg::CTRL_OFF) || (waddr == ssq_pkg::CUR_OFF) ||
		(waddr == ssq_pkg::INT_EN_OFF) || (waddr == ssq_pkg::INT_CLR_OFF);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wst     <= ssq_pkg::SSQ_W_IDLE;
			aw_have <= 1'b0;
			w_have  <= 1'b0;
			awready <= 1'b0;
			wready  <= 1'b0;
			bvalid  <= 1'b0;
			bresp   <= ssq_pkg::RESP_OKAY;
			waddr   <= '0;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
		end else begin
			case (wst)
				ssq_pkg::SSQ_W_IDLE: begin
					if (awvalid && awready) begin
						aw_have <= 1'b1;
						waddr   <= awaddr;
					end
					if (wvalid && wready) begin
						w_have  <= 1'b1;
						wdata_q <= wdata;
						wstrb_q <= wstrb;
					end
					awready <= !aw_have && !(awvalid && awready);
					wready  <= !w_have && !(wvalid && wready);
					if (do_write) begin
						wst    <= ssq_pkg::SSQ_W_RESP;
						bvalid <= 1'b1;
						bresp  <= wr_ok ? ssq_pkg::RESP_OKAY : ssq_pkg::RESP_SLVERR;
					end
				end
				ssq_pkg::SSQ_W_RESP: begin
					if (bready) begin
						bvalid  <= 1'b0;
						aw_have <= 1'b0;
						w_have  <= 1'b0;
						wst     <= ssq_pkg::SSQ_W_IDLE;
					end
				end
				default: wst <= ssq_pkg::SSQ_W_IDLE;
			endcase
		end
	end

	always_comb begin
		rd_ok   = 1'b1;
		rd_word = 32'h0000_0000;
		case (araddr)
			ssq_pkg::CTRL_OFF:     rd_word = ctrl;
			ssq_pkg::CUR_OFF:      rd_word = cur;
			ssq_pkg::STAT_OFF: begin
				rd_word[9:0]                       = mscnt;
				rd_word[ssq_pkg::ST_STST_BIT]      = stst;
				rd_word[ssq_pkg::ST_SCALE_LSB +: 5] = cur_scale;
			end
			ssq_pkg::INT_STAT_OFF: rd_word[ssq_pkg::INT_W-1:0] = int_status;
			ssq_pkg::INT_EN_OFF:   rd_word[ssq_pkg::INT_W-1:0] = int_en;
			ssq_pkg::INT_CLR_OFF:  rd_word = 32'h0000_0000;
			default:               rd_ok = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b0;
			rvalid  <= 1'b0;
			rdata   <= 32'h0000_0000;
			rresp   <= ssq_pkg::RESP_OKAY;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid  <= 1'b1;
			rdata   <= rd_word;
			rresp   <= rd_ok ? ssq_pkg::RESP_OKAY : ssq_pkg::RESP_SLVERR;
		end else if (rvalid) begin
			if (rready)
				rvalid <= 1'b0;
		end else begin
			arready <= 1'b1;
		end
	end

	// current setting register is honoured in every mode
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl   <= ssq_pkg::CTRL_RST;
			cur    <= ssq_pkg::CUR_RST;
			int_en <= '0;
		end else if (do_write) begin
			if (waddr == ssq_pkg::CTRL_OFF)
				ctrl <= ((ctrl & ~wmask) | (wdata_q & wmask)) & ssq_pkg::CTRL_MASK;
			if (waddr == ssq_pkg::CUR_OFF)
				cur <= ((cur & ~wmask) | (wdata_q & wmask)) & ssq_pkg::CUR_MASK; // [R9]
			if (waddr == ssq_pkg::INT_EN_OFF)
				int_en <= (int_en & ~wmask[ssq_pkg::INT_W-1:0]) | (wdata_q[ssq_pkg::INT_W-1:0] & wmask[ssq_pkg::INT_W-1:0]);
		end
	end

	assign int_clr = (do_write && waddr == ssq_pkg::INT_CLR_OFF) ?
		(wdata_q[ssq_pkg::INT_W-1:0] & wmask[ssq_pkg::INT_W-1:0]) : '0;

	// an event in the clearing cycle survives
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			int_status <= '0;
			irq        <= 1'b0;
		end else begin
			int_status <= (int_status & ~int_clr) | int_ev;
			irq        <= |(int_status & int_en);
		end
	end

	// ---------------- step front end ----------------
	assign dedge    = ctrl[ssq_pkg::CTRL_DEDGE];
	assign intpol   = ctrl[ssq_pkg::CTRL_INTPOL];
	assign ext_mode = ctrl[ssq_pkg::CTRL_EXT];
	assign mres     = ctrl[ssq_pkg::CTRL_MRES_LSB +: 4];
	assign n        = (mres > ssq_pkg::MRES_MAX) ? ssq_pkg::MRES_MAX : mres;
	assign wid      = 10'h001 << n; // [R5]
	assign base     = snap(mscnt, n); // [R7] [R8]

	ssq_sync #(
		.W (2)
	) u_pin_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.d       ({dir_in, step_in}), // [R2]
		.q       (pin_s)
	);
	assign step_s = pin_s[0];
	assign dir_s  = pin_s[1];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			step_q <= 1'b0;
			n_prev <= 4'h0;
		end else begin
			step_q <= step_s;
			n_prev <= n;
		end
	end

	// steps are ignored while the sequencer belongs to the internal controller
	assign act       = ext_mode && (step_s != step_q) && (dedge || step_s); // [R1] [R9]
	assign res_lower = n > n_prev;

	// ---------------- microstep counter ----------------
	always_comb begin
		next_mscnt = mscnt;
		if (ext_mode) begin
			if (act && !intpol)
				next_mscnt = dir_s ? base - wid : base + wid; // [R4] [R17]
			else if (act)
				next_mscnt = ip_dir ? mscnt - 10'(remaining) : mscnt + 10'(remaining); // [R16]
			else if (res_lower)
				next_mscnt = base; // [R6]
			else if (intpol && tick && remaining != 9'h000)
				next_mscnt = ip_dir ? mscnt - 10'h001 : mscnt + 10'h001; // [R10]
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			mscnt <= 10'h000;
		else
			mscnt <= next_mscnt; // [R3]
	end

	ssq_wave u_wave_a (
		.aclk    (aclk),
		.aresetn (aresetn),
		.idx     (mscnt), // [R3]
		.amp     (coil_a)
	);

	ssq_wave u_wave_b (
		.aclk    (aclk),
		.aresetn (aresetn),
		.idx     (mscnt + ssq_pkg::COS_OFF),
		.amp     (coil_b)
	);

	// ---------------- interpolator and standstill ----------------
	// spacing uses the interval that just ended, so a rate change lands one interval late
	assign next_spacing = (icnt + 21'h000001) >> n; // [R12] [R16]
	assign tick         = (tcnt + 21'h000001) >= spacing;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			icnt <= '0;
			stst <= 1'b0;
		end else if (act) begin
			icnt <= '0;
			stst <= 1'b0; // [R13]
		end else if (icnt != LIM) begin
			icnt <= icnt + 21'h000001;
		end else begin
			stst <= 1'b1; // [R13]
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			remaining <= 9'h000;
			ip_dir    <= 1'b0;
			spacing   <= 21'h000001;
			tcnt      <= '0;
		end else if (!intpol || !ext_mode) begin
			remaining <= 9'h000; // [R11]
			tcnt      <= '0;
		end else if (act) begin
			remaining <= 9'(wid); // [R10]
			ip_dir    <= dir_s;
			spacing   <= (next_spacing == '0) ? 21'h000001 : next_spacing; // [R12]
			tcnt      <= '0;
		end else if (remaining != 9'h000) begin
			if (tick) begin
				tcnt      <= '0;
				remaining <= remaining - 9'h001;
			end else begin
				tcnt <= tcnt + 21'h000001;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			cur_scale <= 5'h00;
		else if (stst)
			cur_scale <= cur[ssq_pkg::CUR_HOLD_LSB +: 5]; // [R14]
		else
			cur_scale <= cur[ssq_pkg::CUR_RUN_LSB +: 5];
	end

	assign int_ev[ssq_pkg::INT_STST_ON]  = !stst && !act && icnt == LIM;
	assign int_ev[ssq_pkg::INT_STST_OFF] = stst && act;
	assign int_ev[ssq_pkg::INT_INDEX]    = next_mscnt == 10'h000 && mscnt != 10'h000;

	// ---------------- checks ----------------
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	edge_mode_a: assert property (act == (ext_mode && step_s != $past(step_s) && (dedge || step_s))) // [R1]
		else $error("step edge taken against edge mode");
	pin_sync_a: assert property ($past(aresetn, 2) |-> step_s == $past(step_in, 2)) // [R2]
		else $error("step pin not two-stage synchronised");
	wave_sign_a: assert property ($past(aresetn) && coil_a < 0 |-> $past(mscnt[9])) // [R3]
		else $error("coil a sign wrong for table index");
	step_width_a: assert property (act && !intpol |=> // [R4] [R5] [R17]
		mscnt == ($past(dir_s) ? $past(base) - $past(wid) : $past(base) + $past(wid)))
		else $error("step width not applied one cycle after edge");
	grid_pos_a: assert property ($past(act) && !intpol && $stable(n) && n != 4'h0 |-> // [R7] [R8]
		(mscnt & (wid - 10'h001)) == (wid >> 1))
		else $error("counter off the offset grid");
	res_snap_a: assert property (ext_mode && res_lower && !act |=> mscnt == $past(base)) // [R6]
		else $error("counter not snapped on coarser resolution");
	ext_off_a: assert property (!ext_mode |=> mscnt == $past(mscnt)) // [R9]
		else $error("counter moved with step input disabled");
	interp_load_a: assert property (act && intpol |=> remaining == 9'($past(wid))) // [R10]
		else $error("interpolator not loaded with width");
	interp_off_a: assert property (!intpol |=> remaining == 9'h000) // [R11]
		else $error("interpolation running while disabled");
	stst_set_a: assert property (icnt == LIM && !act |=> stst) // [R13]
		else $error("standstill flag not set at limit");
	stst_clr_a: assert property (stst && act |=> !stst) // [R13]
		else $error("standstill flag not cleared on step");
	hold_cur_a: assert property (stst |=> cur_scale == $past(cur[ssq_pkg::CUR_HOLD_LSB +: 5])) // [R14]
		else $error("hold current not selected in standstill");
	jump_a: assert property (act && intpol |=> // [R16]
		mscnt == ($past(ip_dir) ? $past(mscnt) - 10'($past(remaining)) : $past(mscnt) + 10'($past(remaining))))
		else $error("pending microsteps not jumped at edge");
endmodule

/* tb/ssq_step_src.sv */
`timescale 1ns/1ps
module ssq_step_src (
	input  wire logic aclk,
	output logic      step_out,
	output logic      dir_out
);
	initial begin
		step_out = 1'b0;
		dir_out = 1'b0;
	end
	// dir settles a cycle ahead of the active edge and holds past the trailing one
	task automatic pulse(input logic d, input int hi, input int lo);
		dir_out <= d;
		@(posedge aclk);
		step_out <= 1'b1;
		repeat (hi) @(posedge aclk);
		step_out <= 1'b0;
		repeat (lo) @(posedge aclk);
	endtask
endmodule

/* tb/step_dir_microstep_sequencer_tb_top.sv */
`timescale 1ns/1ps
module step_dir_microstep_sequencer_tb_top;
	localparam int LIM = 64;
	localparam logic [33:0] ALL = '1;
	localparam logic [1:0] OK = ssq_pkg::RESP_OKAY;
	logic              aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic              arvalid, arready, rvalid, rready, step_in, dir_in, stst, irq;
	logic        [4:0] awaddr, araddr, cur_scale, h, r;
	logic       [31:0] wdata, rdata, cur;
	logic        [3:0] wstrb;
	logic        [1:0] bresp, rresp;
	logic signed [8:0] coil_a, coil_b;
	logic        [9:0] mscnt, m;
	logic              d;
	logic       [33:0] rexp[$], rmsk[$];
	logic        [1:0] bexp[$];
	int                seed, error_cnt, checked;

	ssq_sequencer #(.STST_CYC(LIM)) DUT (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
		.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
		.rvalid, .rready, .step_in, .dir_in, .coil_a, .coil_b, .cur_scale, .mscnt, .stst, .irq);
	ssq_step_src P (.aclk, .step_out(step_in), .dir_out(dir_in));

	initial aclk = 1'b0;
	always #12.5 aclk = ~aclk;

	task automatic close_out;
		if (error_cnt == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic cmp_v(input logic [33:0] got, input logic [33:0] exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic cmp_rd(input logic [33:0] got, input logic [33:0] exp, input logic [33:0] msk);
		cmp_v(got & msk, exp & msk);
	endtask

	task automatic wr(input logic [4:0] a, input logic [31:0] v, input logic [1:0] e);
		bexp.push_back(e);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
	endtask

	task automatic rd(input logic [4:0] a, input logic [33:0] e, input logic [33:0] msk);
		rexp.push_back(e);
		rmsk.push_back(msk);
		araddr <= a;
		arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
	endtask

	task automatic cnt(input logic [9:0] v);
		cmp_v(34'(mscnt), 34'(v));
		rd(ssq_pkg::STAT_OFF, 34'(v), 34'h3_0000_03ff);
	endtask

	// pipeline is pin + 3 edges, so four idle cycles let the count land
	task automatic stp(input logic dv, input int hi, input int lo);
		P.pulse(dv, hi, lo);
		repeat (4) @(posedge aclk);
	endtask

	function automatic logic [9:0] snp(input logic [9:0] c, input int n);
		return (n == 0) ? c : ((c >> n) << n) + 10'(1 << (n - 1));
	endfunction

	function automatic logic [9:0] nxt(input logic [9:0] c, input int n, input logic dv);
		return dv ? snp(c, n) - 10'(1 << n) : snp(c, n) + 10'(1 << n);
	endfunction

	always @(posedge aclk) begin
		if (rvalid && rready) begin
			cmp_rd({rresp, rdata}, rexp.pop_front(), rmsk.pop_front());
		end
		if (bvalid && bready) begin
			cmp_v(34'(bresp), 34'(bexp.pop_front()));
		end
	end

	initial begin
		repeat (8000) @(posedge aclk);
		error_cnt++;
		close_out();
	end

	initial begin
		seed = 15;
		{awaddr, awvalid, wdata, wvalid, araddr, arvalid} = '0;
		wstrb = 4'hf;
		bready = 1'b1;
		rready = 1'b1;
		aresetn = 1'b0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (3) @(posedge aclk);
		rd(ssq_pkg::CTRL_OFF, 34'h4, ALL);
		rd(ssq_pkg::CUR_OFF, 34'h1f08, ALL);
		rd(5'h18, {ssq_pkg::RESP_SLVERR, 32'h0}, ALL);
		wr(ssq_pkg::STAT_OFF, 32'h1, ssq_pkg::RESP_SLVERR);
		m = 10'h0;
		// 9 is out of range and must behave as fullstep
		for (int n = 0; n < 10; n++) begin
			wr(ssq_pkg::CTRL_OFF, 32'h4 | 32'(n << 4), OK);
			repeat (2) begin
				d = 1'($random(seed));
				stp(d, 2, 2);
				m = nxt(m, (n > 8) ? 8 : n, d);
				cnt(m);
			end
		end
		wr(ssq_pkg::CTRL_OFF, 32'h4, OK);
		stp(1'b0, 2, 2);
		m = m + 10'h1;
		wr(ssq_pkg::CTRL_OFF, 32'h84, OK);
		m = snp(m, 8);
		repeat (2) @(posedge aclk);
		cnt(m);
		cmp_v(34'(coil_a[8] ? -coil_a : coil_a), 34'(coil_b[8] ? -coil_b : coil_b));
		cmp_v(34'({coil_a[8], coil_b[8], coil_a != 9'sh000}), 34'({m[9], m[9] ^ m[8], 1'b1}));
		wr(ssq_pkg::CTRL_OFF, 32'h5, OK);
		stp(1'b0, 3, 3);
		m = m + 10'h2;
		cnt(m);
		wr(ssq_pkg::CTRL_OFF, 32'h0, OK);
		stp(1'b0, 2, 2);
		cnt(m);
		cur = $random(seed);
		h = cur[4:0];
		r = cur[12:8];
		wr(ssq_pkg::CUR_OFF, {19'h0, r, 3'h0, h}, OK);
		wr(ssq_pkg::CTRL_OFF, 32'h4, OK);
		repeat (LIM + 8) @(posedge aclk);
		cmp_v(34'(stst), 34'h1);
		cmp_v(34'(cur_scale), 34'(h));
		cmp_v(34'(irq), 34'h0);
		rd(ssq_pkg::INT_STAT_OFF, 34'h1, 34'h3_0000_0001);
		wr(ssq_pkg::INT_EN_OFF, 32'h1, OK);
		repeat (2) @(posedge aclk);
		cmp_v(34'(irq), 34'h1);
		wr(ssq_pkg::INT_CLR_OFF, 32'h1, OK);
		repeat (2) @(posedge aclk);
		cmp_v(34'(irq), 34'h0);
		rd(ssq_pkg::INT_CLR_OFF, 34'h0, ALL);
		stp(1'b0, 2, 2);
		m = m + 10'h1;
		cmp_v(34'(stst), 34'h0);
		cmp_v(34'(cur_scale), 34'(r));
		cnt(m);
		// steady 41-cycle spacing, resolution setting 2, four fine steps per edge
		wr(ssq_pkg::CTRL_OFF, 32'h26, OK);
		repeat (3) P.pulse(1'b0, 2, 38);
		repeat (10) @(posedge aclk);
		cnt(snp(m, 2) + 10'd12);
		rd(ssq_pkg::INT_STAT_OFF, 34'h2, 34'h3_0000_0002);
		repeat (4) @(posedge aclk);
		close_out();
	end
endmodule
